/* pkg/bsim_defines.vh */
// Constants for the boot selector and internal memory block
`ifndef BSIM_DEFINES_VH
`define BSIM_DEFINES_VH

// ----------------------------------------------------------------------
// Boot selections
// ----------------------------------------------------------------------
`define BSIM_BOOT_ROM 2'h0
`define BSIM_BOOT_CUSTOM 2'h1
`define BSIM_BOOT_IMAGE 2'h2

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define BSIM_IMEM_BASE 32'h00000000
`define BSIM_DMEM_BASE 32'h80000000
`define BSIM_BROM_BASE 32'hFFE00000
`define BSIM_IO_TAG 11'h7FF
`define BSIM_IO_TAG_MSB 31
`define BSIM_IO_TAG_LSB 21
`define BSIM_SLOT_MSB 20
`define BSIM_SLOT_LSB 16
`define BSIM_SLOT_BROM 5'h00
`define BSIM_SLOT_SYSREG 5'h01
`define BSIM_BROM_IDX_MSB 5
`define BSIM_REG_IDX_MSB 3
`define BSIM_WORD_LSB 2

// ----------------------------------------------------------------------
// Status registers of the own IO window (word index inside the window)
// ----------------------------------------------------------------------
`define BSIM_REG_CFG 2'h0
`define BSIM_REG_FSTAT 2'h1
`define BSIM_REG_FADDR 2'h2

// Configuration register fields
`define BSIM_CFG_MODE_LSB 0
`define BSIM_CFG_IMEM_EN 2
`define BSIM_CFG_DMEM_EN 3
`define BSIM_CFG_IMEM_ROM 4
`define BSIM_CFG_ERR 5
`define BSIM_CFG_BROM_EN 6
`define BSIM_CFG_IAW_LSB 8
`define BSIM_CFG_DAW_LSB 16

// Fault status fields, write one to clear
`define BSIM_FST_FETCH 0
`define BSIM_FST_LOAD 1
`define BSIM_FST_STORE 2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BSIM_BUS_TIMEOUT 5'h0F
`define BSIM_CNT_ONE 5'h01

`endif

/* verilog/bsim_top.v */
// Boot selection, internal instruction/data memories and IO access rules
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "bsim_defines.vh"

module bsim_top #(
  parameter [1:0] BOOT_MODE = 2'h0,
  parameter [31:0] BOOT_ADDR_CUSTOM = 32'h00000000,
  parameter IMEM_EN = 1,
  parameter IMEM_SIZE = 64,
  parameter DMEM_EN = 1,
  parameter DMEM_SIZE = 64
)(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_fetch_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire wb_err_o,
  output wire [31:0] boot_addr_o,
  output wire boot_rom_en_o,
  output wire config_err_o,
  output wire fault_fetch_o,
  output wire fault_load_o,
  output wire fault_store_o
);

  // ----------------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------------
  localparam IMEM_AW = $clog2(IMEM_SIZE);
  localparam DMEM_AW = $clog2(DMEM_SIZE);
  localparam IMEM_WORDS = 1 << (IMEM_AW - 2);
  localparam DMEM_WORDS = 1 << (DMEM_AW - 2);
  localparam [31:0] IMEM_MASK = (32'h1 << IMEM_AW) - 32'h1;
  localparam [31:0] DMEM_MASK = (32'h1 << DMEM_AW) - 32'h1;
  localparam IMEM_ROM = (BOOT_MODE == `BSIM_BOOT_IMAGE);
  localparam BROM_EN = (BOOT_MODE == `BSIM_BOOT_ROM);
  localparam CUST_MISALIGNED = (BOOT_ADDR_CUSTOM[1:0] != 2'h0);
  localparam CFG_BAD = ((BOOT_MODE == `BSIM_BOOT_CUSTOM) && CUST_MISALIGNED)
    || ((BOOT_MODE == `BSIM_BOOT_IMAGE) && (IMEM_EN == 0))
    || (BOOT_MODE > `BSIM_BOOT_IMAGE);
  // Misaligned custom address is forced to the word below
  localparam [31:0] BOOT_VAL =
    (BOOT_MODE == `BSIM_BOOT_ROM) ? `BSIM_BROM_BASE :
    (BOOT_MODE == `BSIM_BOOT_CUSTOM) ?
      {BOOT_ADDR_CUSTOM[31:2], 2'h0} :
    `BSIM_IMEM_BASE;

  // ----------------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_DONE = 5'b00010;
  localparam [4:0] ST_IOREQ = 5'b00100;
  localparam [4:0] ST_IORSP = 5'b01000;
  localparam [4:0] ST_WAIT = 5'b10000;
  reg [4:0] state_r, cnt_r;
  reg ack_r, err_r, req_we_r, req_fetch_r, io_err_r;
  reg [31:0] dat_r, req_adr_r, req_dat_r, io_dat_r, faddr_r;
  reg [2:0] fstat_r, fstat_nxt;
  reg fault_fetch_r, fault_load_r, fault_store_r;
  reg [31:0] boot_addr_r;
  reg boot_rom_en_r, config_err_r;
  wire req = wb_cyc_i & wb_stb_i & (state_r == ST_IDLE);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire hit_imem = (IMEM_EN != 0) &&
    ((wb_adr_i & ~IMEM_MASK) == `BSIM_IMEM_BASE);
  wire hit_dmem = (DMEM_EN != 0) &&
    ((wb_adr_i & ~DMEM_MASK) == `BSIM_DMEM_BASE);
  wire hit_io = (wb_adr_i[`BSIM_IO_TAG_MSB:`BSIM_IO_TAG_LSB] == `BSIM_IO_TAG);
  // Fetch and data accesses alike reach the data memory
  wire hit_mem = hit_imem | hit_dmem;
  wire rom_write = hit_imem & wb_we_i & IMEM_ROM;

  // ----------------------------------------------------------------------
  // Instruction memory
  // ----------------------------------------------------------------------
  wire [31:0] imem_rdata;
  wire imem_wr = req & hit_imem & wb_we_i & ~IMEM_ROM;
  generate
    if ((IMEM_EN != 0) && IMEM_ROM)
    begin : g_imem_rom
      wire [IMEM_AW-3:0] idx = wb_adr_i[IMEM_AW-1:`BSIM_WORD_LSB];
      // Image lives in logic only; no write path exists
      assign imem_rdata = bsim_app_word(idx);
    end
    else if (IMEM_EN != 0)
    begin : g_imem_ram
      // No initial block: contents undefined until written
      reg [31:0] mem [0:IMEM_WORDS-1];
      wire [IMEM_AW-3:0] idx = wb_adr_i[IMEM_AW-1:`BSIM_WORD_LSB];
      integer b;
      always @(posedge clk_i)
      begin
        for (b = 0; b < 4; b = b + 1)
          if (imem_wr && wb_sel_i[b])
            mem[idx][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
      assign imem_rdata = mem[idx];
    end
    else
    begin : g_imem_none
      assign imem_rdata = 32'h00000000;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------------
  wire [31:0] dmem_rdata;
  wire dmem_wr = req & hit_dmem & wb_we_i;
  generate
    if (DMEM_EN != 0)
    begin : g_dmem_ram
      reg [31:0] mem [0:DMEM_WORDS-1];
      wire [DMEM_AW-3:0] idx = wb_adr_i[DMEM_AW-1:`BSIM_WORD_LSB];
      integer b;
      always @(posedge clk_i)
      begin
        for (b = 0; b < 4; b = b + 1)
          if (dmem_wr && wb_sel_i[b])
            mem[idx][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
      assign dmem_rdata = mem[idx];
    end
    else
    begin : g_dmem_none
      assign dmem_rdata = 32'h00000000;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Preloaded images
  // ----------------------------------------------------------------------
  // Application image; unlisted words hold a no-op
  function [31:0] bsim_app_word;
    input [IMEM_AW-3:0] idx;
    begin
      case (idx)
        0: bsim_app_word = 32'h00000093;
        1: bsim_app_word = 32'h00108093;
        2: bsim_app_word = 32'hFFDFF06F;
        default: bsim_app_word = 32'h00000013;
      endcase
    end
  endfunction
  // Boot loader image, sixteen words mirrored over the window
  function [31:0] bsim_brom_word;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: bsim_brom_word = 32'h80000137;
        4'h1: bsim_brom_word = 32'h00000093;
        4'h2: bsim_brom_word = 32'h0000006F;
        default: bsim_brom_word = 32'h00000013;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // IO switch: slot decode on the registered request
  // ----------------------------------------------------------------------
  wire [4:0] io_slot = req_adr_r[`BSIM_SLOT_MSB:`BSIM_SLOT_LSB];
  wire [1:0] io_reg = req_adr_r[`BSIM_REG_IDX_MSB:`BSIM_WORD_LSB];
  wire [3:0] brom_idx = req_adr_r[`BSIM_BROM_IDX_MSB:`BSIM_WORD_LSB];
  wire [31:0] cfg_word = ({30'h0, BOOT_MODE} << `BSIM_CFG_MODE_LSB)
    | ({31'h0, (IMEM_EN != 0)} << `BSIM_CFG_IMEM_EN)
    | ({31'h0, (DMEM_EN != 0)} << `BSIM_CFG_DMEM_EN)
    | ({31'h0, IMEM_ROM} << `BSIM_CFG_IMEM_ROM)
    | ({31'h0, config_err_r} << `BSIM_CFG_ERR)
    | ({31'h0, boot_rom_en_r} << `BSIM_CFG_BROM_EN)
    | ({24'h0, IMEM_AW[7:0]} << `BSIM_CFG_IAW_LSB)
    | ({24'h0, DMEM_AW[7:0]} << `BSIM_CFG_DAW_LSB);
  reg [31:0] io_rsp_dat;
  reg io_rsp_err, fstat_clr_en;
  always @*
  begin
    io_rsp_dat = 32'h00000000;
    io_rsp_err = 1'b0;
    fstat_clr_en = 1'b0;
    case (io_slot)
      `BSIM_SLOT_BROM:
      begin
        io_rsp_err = !BROM_EN || req_we_r;
        if (!io_rsp_err)
          io_rsp_dat = bsim_brom_word(brom_idx);
      end
      `BSIM_SLOT_SYSREG:
      begin
        case (io_reg)
          `BSIM_REG_CFG:
            io_rsp_dat = req_we_r ? 32'h00000000 : cfg_word;
          `BSIM_REG_FSTAT:
          begin
            io_rsp_dat = req_we_r ? 32'h00000000 : {29'h0, fstat_r};
            fstat_clr_en = req_we_r;
          end
          `BSIM_REG_FADDR:
            io_rsp_dat = req_we_r ? 32'h00000000 : faddr_r;
          default:
            io_rsp_dat = 32'h00000000;
        endcase
      end
      default:
        io_rsp_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // Error events and fault status
  // ----------------------------------------------------------------------
  wire tmo_hit = (state_r == ST_WAIT) &&
    (cnt_r == `BSIM_BUS_TIMEOUT - `BSIM_CNT_ONE);
  wire err_set = (req & rom_write)
    | ((state_r == ST_IORSP) & io_err_r)
    | tmo_hit;
  wire cur_fetch = (state_r == ST_IDLE) ? wb_fetch_i : req_fetch_r;
  wire cur_we = (state_r == ST_IDLE) ? wb_we_i : req_we_r;
  wire [31:0] cur_adr = (state_r == ST_IDLE) ? wb_adr_i : req_adr_r;
  wire set_fetch = err_set & cur_fetch & ~cur_we;
  wire set_load = err_set & ~cur_fetch & ~cur_we;
  wire set_store = err_set & cur_we;
  always @*
  begin
    fstat_nxt = fstat_r;
    // Clear first, so an event in the same cycle survives
    if ((state_r == ST_IOREQ) && fstat_clr_en)
      fstat_nxt = fstat_nxt & ~req_dat_r[2:0];
    fstat_nxt[`BSIM_FST_FETCH] = fstat_nxt[`BSIM_FST_FETCH] | set_fetch;
    fstat_nxt[`BSIM_FST_LOAD] = fstat_nxt[`BSIM_FST_LOAD] | set_load;
    fstat_nxt[`BSIM_FST_STORE] = fstat_nxt[`BSIM_FST_STORE] | set_store;
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fstat_r <= 3'h0;
      faddr_r <= 32'h00000000;
      fault_fetch_r <= 1'b0;
      fault_load_r <= 1'b0;
      fault_store_r <= 1'b0;
    end
    else
    begin
      fstat_r <= fstat_nxt;
      if (err_set)
        faddr_r <= cur_adr;
      // Fault pulses line up with the error answer
      fault_fetch_r <= set_fetch;
      fault_load_r <= set_load;
      fault_store_r <= set_store;
    end
  end

  // ----------------------------------------------------------------------
  // Boot configuration outputs
  // ----------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      boot_addr_r <= BOOT_VAL;
      boot_rom_en_r <= BROM_EN;
      config_err_r <= CFG_BAD;
    end
  end

  // ----------------------------------------------------------------------
  // Bus sequencing
  // ----------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h00000000;
      req_adr_r <= 32'h00000000;
      req_we_r <= 1'b0;
      req_dat_r <= 32'h00000000;
      req_fetch_r <= 1'b0;
      io_dat_r <= 32'h00000000;
      io_err_r <= 1'b0;
      cnt_r <= 5'h00;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (req)
          begin
            req_adr_r <= wb_adr_i;
            req_we_r <= wb_we_i;
            req_dat_r <= wb_dat_i;
            req_fetch_r <= wb_fetch_i;
            cnt_r <= `BSIM_CNT_ONE;
            if (hit_mem)
            begin
              // Memories answer on the next cycle
              err_r <= rom_write;
              ack_r <= ~rom_write;
              dat_r <= wb_we_i ? 32'h00000000 :
                (hit_imem ? imem_rdata : dmem_rdata);
              state_r <= ST_DONE;
            end
            else if (hit_io)
              state_r <= ST_IOREQ;
            else
              state_r <= ST_WAIT;
          end
        end
        ST_IOREQ:
        begin
          // Response stage register of the IO switch
          io_dat_r <= io_rsp_dat;
          io_err_r <= io_rsp_err;
          state_r <= ST_IORSP;
        end
        ST_IORSP:
        begin
          ack_r <= ~io_err_r;
          err_r <= io_err_r;
          dat_r <= io_dat_r;
          state_r <= ST_DONE;
        end
        ST_WAIT:
        begin
          cnt_r <= cnt_r + `BSIM_CNT_ONE;
          if (tmo_hit)
          begin
            err_r <= 1'b1;
            dat_r <= 32'h00000000;
            state_r <= ST_DONE;
          end
        end
        default:
        begin
          // Done state and stray codes: master releases after the answer
          ack_r <= 1'b0;
          err_r <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign boot_addr_o = boot_addr_r;
  assign boot_rom_en_o = boot_rom_en_r;
  assign config_err_o = config_err_r;
  assign fault_fetch_o = fault_fetch_r;
  assign fault_load_o = fault_load_r;
  assign fault_store_o = fault_store_r;

endmodule

/* verification/bsim_top_monitor.sv */
// Assertion checker for the boot selector and internal memories
`timescale 1ns/1ps
`include "bsim_defines.vh"
module bsim_top_monitor #(
  parameter [1:0] BOOT_MODE = 2'h0,
  parameter [31:0] BOOT_ADDR_CUSTOM = 32'h00000000,
  parameter IMEM_EN = 1,
  parameter IMEM_SIZE = 64
)(
  input wire clk_i,
  input wire rst_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire wb_fetch_i,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire [31:0] boot_addr_o,
  input wire boot_rom_en_o,
  input wire fault_fetch_o,
  input wire fault_load_o,
  input wire fault_store_o
);
  localparam [31:0] EXP_BOOT = (BOOT_MODE == `BSIM_BOOT_ROM) ?
    `BSIM_BROM_BASE : (BOOT_MODE == `BSIM_BOOT_CUSTOM) ?
    {BOOT_ADDR_CUSTOM[31:2], 2'h0} : `BSIM_IMEM_BASE;
  localparam [31:0] IMEM_SPAN = 32'h1 << $clog2(IMEM_SIZE);
  logic stb_q;
  logic start;
  logic rsp;
  logic imem_hit;
  assign start = wb_stb_i && !stb_q;
  assign rsp = wb_ack_o || wb_err_o;
  assign imem_hit = (IMEM_EN != 0) && (wb_adr_i < IMEM_SPAN);
  always @(posedge clk_i)
  begin
    if (rst_i)
      stb_q <= 1'b0;
    else
      stb_q <= wb_stb_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_err_fault: assert property ($onehot0({fault_fetch_o, fault_load_o,
    fault_store_o}) && (wb_err_o == (fault_fetch_o || fault_load_o ||
    fault_store_o))) else $error("fault pulse not paired with err");
  a_store_fault: assert property (wb_err_o && wb_we_i |-> fault_store_o)
    else $error("write error without store fault");
  a_fetch_fault: assert property (wb_err_o && !wb_we_i && wb_fetch_i
    |-> fault_fetch_o) else $error("fetch error without fetch fault");
  a_boot_const: assert property (boot_addr_o == EXP_BOOT &&
    boot_rom_en_o == (BOOT_MODE == `BSIM_BOOT_ROM))
    else $error("boot address or boot rom enable wrong");
  a_mem_latency: assert property (start && imem_hit |=> rsp)
    else $error("memory answer not in next cycle");
  a_imem_write: assert property (start && imem_hit && wb_we_i
    |=> (BOOT_MODE == `BSIM_BOOT_IMAGE) ? wb_err_o : wb_ack_o)
    else $error("instruction memory write answer wrong");
  a_io_latency: assert property (start &&
    wb_adr_i[31:21] == `BSIM_IO_TAG |=> !rsp ##1 !rsp ##1 rsp)
    else $error("io answer not in third cycle");
  a_hole_timeout: assert property (start && wb_adr_i[31:28] == 4'h4
    |=> (!rsp)[*7] ##1 (!rsp)[*7] ##1 wb_err_o)
    else $error("hole access not timed out at 15");
  c_io_ack: cover property (start && wb_adr_i[31:21] == `BSIM_IO_TAG
    ##3 wb_ack_o);
  c_hole_err: cover property (start && wb_adr_i[31:28] == 4'h4 ##15 wb_err_o);
  c_rom_write: cover property (start && imem_hit && wb_we_i ##1 wb_err_o);
endmodule

bind bsim_top bsim_top_monitor #(
  .BOOT_MODE(BOOT_MODE),
  .BOOT_ADDR_CUSTOM(BOOT_ADDR_CUSTOM),
  .IMEM_EN(IMEM_EN),
  .IMEM_SIZE(IMEM_SIZE)
) u_bsim_top_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_fetch_i(wb_fetch_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .boot_addr_o(boot_addr_o),
  .boot_rom_en_o(boot_rom_en_o), .fault_fetch_o(fault_fetch_o),
  .fault_load_o(fault_load_o), .fault_store_o(fault_store_o)
);

/* verification/bsim_cpu_model.sv */
// Bus master model standing in for the CPU bus interface
`timescale 1ns/1ps
module bsim_cpu_model (
  input wire clk_i,
  input wire wb_ack_i,
  input wire wb_err_i,
  input wire [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [31:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  output logic wb_fetch_o
);
  initial
  begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_fetch_o} = 4'h0;
    wb_adr_o = 32'h00000000;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h00000000;
  end
  // One request at a time, held until ack, err or 40 cycles; the caller passes
  // full words to IO space
  task automatic xfer(input logic we, input logic fch,
    input logic [31:0] adr, input logic [3:0] sel, input logic [31:0] wd,
    output logic [31:0] rd, output logic ack, output logic err,
    output int lat);
    lat = 0;
    ack = 1'b0;
    err = 1'b0;
    rd = 32'h00000000;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_fetch_o <= fch;
    wb_adr_o <= adr;
    wb_sel_o <= sel;
    wb_dat_o <= wd;
    while (!ack && !err && lat < 40)
    begin
      @(posedge clk_i);
      ack = wb_ack_i;
      err = wb_err_i;
      rd = wb_dat_i;
      lat++;
    end
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Released lines must not keep showing the last value
    wb_adr_o <= ~adr;
    wb_dat_o <= ~wd;
    @(posedge clk_i);
  endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench for boot selection and internal memories
`timescale 1ns/1ps
`include "bsim_defines.vh"
module tb_top;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_fetch;
  logic [31:0] wb_adr, wb_dat;
  logic [3:0] wb_sel;
  logic [2:0] ack_w, err_w, ren_w, cerr_w;
  logic cerr_noimem;
  logic [2:0][31:0] dat_w, ba_w;
  logic [31:0] imem_m [16];
  logic [31:0] dmem_m [16];
  int n_fail, n_compared, pick;
  // --------------------------------------------------------------
  // One instance per boot selection, all on the same bus
  // --------------------------------------------------------------
  for (genvar m = 0; m < 3; m++)
  begin : g_mode
    bsim_top #(.BOOT_MODE(2'(m)), .BOOT_ADDR_CUSTOM(32'h00001236),
      .IMEM_SIZE(48)) u_bsim_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat), .wb_fetch_i(wb_fetch), .wb_dat_o(dat_w[m]),
      .wb_ack_o(ack_w[m]), .wb_err_o(err_w[m]), .boot_addr_o(ba_w[m]),
      .boot_rom_en_o(ren_w[m]), .config_err_o(cerr_w[m]),
      .fault_fetch_o(), .fault_load_o(), .fault_store_o());
  end
  // Image boot without instruction memory must be flagged
  if (1)
  begin : g_noimem
    bsim_top #(.BOOT_MODE(`BSIM_BOOT_IMAGE), .IMEM_EN(0)) u_bsim_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(1'b0), .wb_stb_i(1'b0),
      .wb_we_i(1'b0), .wb_adr_i(32'h00000000), .wb_sel_i(4'h0),
      .wb_dat_i(32'h00000000), .wb_fetch_i(1'b0), .wb_dat_o(),
      .wb_ack_o(), .wb_err_o(), .boot_addr_o(), .boot_rom_en_o(),
      .config_err_o(cerr_noimem), .fault_fetch_o(), .fault_load_o(),
      .fault_store_o());
  end
  bsim_cpu_model u_bsim_cpu_model (
    .clk_i(clk_i), .wb_ack_i(ack_w[pick]), .wb_err_i(err_w[pick]),
    .wb_dat_i(dat_w[pick]), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
    .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel),
    .wb_dat_o(wb_dat), .wb_fetch_o(wb_fetch));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Checks answer kind and the cycle it came in
  task automatic acc(input logic we, input logic fch, input logic [31:0] a,
    input logic [3:0] s, input logic [31:0] wd, input logic ok_x,
    input int cyc_x, output logic [31:0] rd);
    logic ok;
    logic bad;
    int lat;
    u_bsim_cpu_model.xfer(we, fch, a, s, wd, rd, ok, bad, lat);
    if (lat >= 40)
    begin
      n_fail++;
      complete_run();
    end
    check({31'h0, ok}, {31'h0, ok_x});
    check(32'(lat - 1), 32'(cyc_x));
  endtask
  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b])
        o[8*b +: 8] = n[8*b +: 8];
    return o;
  endfunction
  initial
  begin
    logic [31:0] rd, a, d;
    logic [3:0] s;
    int w;
    n_fail = 0;
    n_compared = 0;
    pick = 0;
    rst_i = 1'b1;
    d = $urandom(81);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(ba_w[0], `BSIM_BROM_BASE);
    check(ba_w[1], 32'h00001234);
    check(ba_w[2], `BSIM_IMEM_BASE);
    check({26'h0, ren_w, cerr_w}, 32'h0000000A);
    check({31'h0, cerr_noimem}, 32'h00000001);
    for (w = 0; w < 16; w++)
    begin
      d = $urandom;
      imem_m[w] = d;
      acc(1, 0, `BSIM_IMEM_BASE + 32'(4*w), 4'hF, d, 1, 1, rd);
      d = $urandom;
      dmem_m[w] = d;
      acc(1, 0, `BSIM_DMEM_BASE + 32'(4*w), 4'hF, d, 1, 1, rd);
    end
    repeat (40)
    begin
      w = $urandom_range(15);
      s = 4'($urandom);
      d = $urandom;
      a = ($urandom_range(1) ? `BSIM_DMEM_BASE : `BSIM_IMEM_BASE) + 32'(4*w);
      acc(1, 0, a, s, d, 1, 1, rd);
      if (a[31])
        dmem_m[w] = merge(dmem_m[w], d, s);
      else
        imem_m[w] = merge(imem_m[w], d, s);
      acc(0, a[31], a, 4'hF, 0, 1, 1, rd);
      check(rd, a[31] ? dmem_m[w] : imem_m[w]);
    end
    acc(0, 0, 32'h0000003C, 4'hF, 0, 1, 1, rd);
    check(rd, imem_m[15]);
    acc(0, 0, 32'h00000040, 4'hF, 0, 0, 15, rd);
    acc(0, 1, 32'h40000000, 4'hF, 0, 0, 15, rd);
    acc(1, 0, 32'h40000000, 4'hF, 0, 0, 15, rd);
    acc(0, 0, 32'hFFE10008, 4'hF, 0, 1, 3, rd);
    check(rd, 32'h40000000);
    acc(0, 0, 32'hFFE10004, 4'hF, 0, 1, 3, rd);
    check(rd, 32'h00000007);
    acc(1, 0, 32'hFFE10004, 4'hF, 32'h00000007, 1, 3, rd);
    acc(0, 0, 32'hFFE10004, 4'hF, 0, 1, 3, rd);
    check(rd, 32'h00000000);
    acc(0, 0, 32'hFFE10000, 4'hF, 0, 1, 3, rd);
    check(rd, 32'h0006064C);
    acc(1, 0, 32'hFFE1FFF0, 4'hF, 32'hFFFFFFFF, 1, 3, rd);
    acc(0, 0, 32'hFFE1FFF0, 4'hF, 0, 1, 3, rd);
    check(rd, 32'h0006064C);
    acc(0, 0, `BSIM_BROM_BASE + 32'hFFC0, 4'hF, 0, 1, 3, rd);
    check(rd, 32'h80000137);
    acc(1, 0, `BSIM_BROM_BASE, 4'hF, 0, 0, 3, rd);
    acc(0, 0, 32'hFFE50000, 4'hF, 0, 0, 3, rd);
    pick = 1;
    acc(0, 0, 32'hFFE10000, 4'hF, 0, 1, 3, rd);
    check(rd, 32'h0006062D);
    acc(0, 0, `BSIM_BROM_BASE, 4'hF, 0, 0, 3, rd);
    acc(0, 0, 32'h0000000C, 4'hF, 0, 1, 1, rd);
    check(rd, imem_m[3]);
    pick = 2;
    acc(0, 0, 32'hFFE10000, 4'hF, 0, 1, 3, rd);
    check(rd, 32'h0006061E);
    acc(0, 1, 32'h00000008, 4'hF, 0, 1, 1, rd);
    check(rd, 32'hFFDFF06F);
    acc(1, 0, 32'h00000000, 4'hF, 32'h12345678, 0, 1, rd);
    acc(0, 0, 32'h00000000, 4'hF, 0, 1, 1, rd);
    check(rd, 32'h00000093);
    complete_run();
  end
endmodule
